/* File: frame_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module frame_host_model (
    // clock, reset, control
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic stall_i,
    input wire logic clear_i,
    // byte stream
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    output var logic tx_ready_o,
    // parsed frame
    output var logic [7:0] frame_o [27],
    output var logic [5:0] count_o,
    output var logic [5:0] last_at_o,
    output var logic csum_ok_o,
    output var logic signed [15:0] temp_o
);
    logic [1:0] phase_reg;
    logic [7:0] sum_reg;
    logic take;
    logic [15:0] t;

    assign take = tx_valid_i && tx_ready_o;
    assign t = {frame_o[24], tx_data_i};

    // ready only one cycle in four while stalling
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg <= 2'h0;
            tx_ready_o <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            tx_ready_o <= !stall_i || (phase_reg == 2'h3);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (take && count_o < 6'd27) begin
            frame_o[count_o] <= tx_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i || clear_i) begin
            count_o <= 6'h0;
            sum_reg <= 8'h0;
            last_at_o <= 6'h3F;
            csum_ok_o <= 1'b0;
            temp_o <= 16'h0;
        end else if (take) begin
            count_o <= count_o + 6'h1;
            if (count_o >= 6'd3) begin
                sum_reg <= sum_reg + tx_data_i;
            end
            if (tx_last_i) begin
                last_at_o <= count_o;
            end
            if (count_o == 6'd26) begin
                csum_ok_o <= (sum_reg + tx_data_i) == 8'hFF;
            end
            if (count_o == 6'd25) begin
                temp_o <= (t < 16'd2048) ? t : -$signed({5'h0, t[10:0]});
            end
        end
    end
endmodule

`default_nettype wire

/* File: frame_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface frame_mem_if;
    logic we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [4:0] raddr;
    logic [7:0] rdata;

    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

/* File: frame_store.sv */
`timescale 1ns/100ps
`default_nettype none

module frame_store
    import sensor_frame_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // frame byte port
    frame_mem_if.store bus
);

    logic [7:0] mem_reg [FRAME_BYTES];
    logic [7:0] rdata_reg;

    always_ff @(posedge mclk_i) begin
        if (ce_i && bus.we) begin
            mem_reg[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= BYTE_RESET;
        end else if (ce_i) begin
            rdata_reg <= mem_reg[bus.raddr];
        end
    end

    assign bus.rdata = rdata_reg;

endmodule

`default_nettype wire

/* File: sensor_frame_pkg.sv */
package sensor_frame_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR_HI = 8'h04;
    localparam logic [7:0] OFS_ADDR_LO = 8'h08;
    localparam logic [7:0] OFS_NET = 8'h0C;
    localparam logic [7:0] OFS_RXOPT = 8'h10;
    localparam logic [7:0] OFS_AD_AB = 8'h14;
    localparam logic [7:0] OFS_AD_CD = 8'h18;
    localparam logic [7:0] OFS_TEMP = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // control and status bit positions
    localparam int CTRL_AOO_BIT = 0;
    localparam int CTRL_AD_BIT = 1;
    localparam int CTRL_TEMP_BIT = 2;
    localparam int CTRL_LAUNCH_BIT = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WATER_BIT = 1;
    localparam int ST_DROP_BIT = 2;
    localparam int ST_COUNT_LSB = 8;

    // values after reset
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [15:0] HALF_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] WATER_SYNC_RESET = 3'h7;

    // frame byte positions
    localparam logic [4:0] IDX_START = 5'h00;
    localparam logic [4:0] IDX_LEN_MSB = 5'h01;
    localparam logic [4:0] IDX_LEN_LSB = 5'h02;
    localparam logic [4:0] IDX_TYPE = 5'h03;
    localparam logic [4:0] IDX_ADDR_FIRST = 5'h04;
    localparam logic [4:0] IDX_ADDR_LAST = 5'h0B;
    localparam logic [4:0] IDX_NET_MSB = 5'h0C;
    localparam logic [4:0] IDX_NET_LSB = 5'h0D;
    localparam logic [4:0] IDX_RXOPT = 5'h0E;
    localparam logic [4:0] IDX_FLAGS = 5'h0F;
    localparam logic [4:0] IDX_AD_FIRST = 5'h10;
    localparam logic [4:0] IDX_AD_LAST = 5'h17;
    localparam logic [4:0] IDX_TEMP_MSB = 5'h18;
    localparam logic [4:0] IDX_TEMP_LSB = 5'h19;
    localparam logic [4:0] IDX_CSUM = 5'h1A;
    localparam int FRAME_BYTES = 27;

    // frame field values
    localparam logic [7:0] START_DELIM = 8'h7E;
    localparam logic [7:0] FRAME_TYPE = 8'h94;
    localparam logic [15:0] FRAME_LEN = 16'h0017;
    localparam logic [7:0] CSUM_BASE = 8'hFF;
    localparam logic [7:0] RXOPT_MASK = 8'h23;
    localparam logic [7:0] FLAG_AD = 8'h01;
    localparam logic [7:0] FLAG_TEMP = 8'h02;
    localparam logic [7:0] FLAG_WATER = 8'h60;
    localparam logic [15:0] NO_READING = 16'hFFFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FILL = 3'b001,
        ST_RD = 3'b010,
        ST_LD = 3'b011,
        ST_WAIT = 3'b100
    } frame_state_type;

endpackage

/* File: sensor_read_frame_builder.sv */
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module sensor_read_frame_builder
    import sensor_frame_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sensor pin
    input wire logic water_detect_input_i,
    // serial byte stream
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o
);

    function automatic logic [31:0] wr_merge(input logic [31:0] cur, input logic [31:0] din,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = cur;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = din[8*i +: 8];
            end
        end
        return res;
    endfunction

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [2:0] ctrl_reg;
    logic [31:0] addr_hi_reg;
    logic [31:0] addr_lo_reg;
    logic [15:0] net_reg;
    logic [7:0] rxopt_reg;
    logic [31:0] ad_ab_reg;
    logic [31:0] ad_cd_reg;
    logic [15:0] temp_reg;
    logic drop_reg;
    logic [7:0] count_reg;
    logic [2:0] water_sync_reg;
    logic water_level_reg;
    frame_state_type state_reg;
    logic [4:0] fill_idx_reg;
    logic [4:0] send_idx_reg;
    logic [7:0] csum_reg;
    logic [31:0] cur_word;
    logic [31:0] merged_word;
    logic [7:0] fill_byte;
    logic [7:0] flags_byte;
    logic [2:0] addr_sel;
    logic [2:0] ad_sel;
    logic [63:0] addr_word;
    logic [63:0] ad_word;
    logic [15:0] temp_word;
    logic wb_req;
    logic wb_wr;
    logic busy;
    logic launch;
    logic frame_go;
    logic drop_set;
    logic drop_clr;
    logic water_present;
    logic tx_fire;

    frame_mem_if mem_bus ();

    frame_store u_store (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .bus(mem_bus.store)
    );

    // reset release
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && ce_i;
    assign busy = (state_reg != ST_IDLE);
    assign water_present = !water_level_reg;
    assign tx_fire = ce_i && tx_valid_o && tx_ready_i;
    assign launch = wb_wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[1] && wb_dat_i[CTRL_LAUNCH_BIT];
    assign frame_go = launch && !busy && !merged_word[CTRL_AOO_BIT];
    assign drop_set = launch && busy;
    assign drop_clr = wb_wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_DROP_BIT];

    always_comb begin
        case (wb_adr_i)
            OFS_CTRL: cur_word = {29'h0, ctrl_reg};
            OFS_ADDR_HI: cur_word = addr_hi_reg;
            OFS_ADDR_LO: cur_word = addr_lo_reg;
            OFS_NET: cur_word = {16'h0000, net_reg};
            OFS_RXOPT: cur_word = {24'h00_0000, rxopt_reg};
            OFS_AD_AB: cur_word = ad_ab_reg;
            OFS_AD_CD: cur_word = ad_cd_reg;
            OFS_TEMP: cur_word = {16'h0000, temp_reg};
            OFS_STATUS: cur_word = {16'h0000, count_reg, 5'h00, drop_reg, water_present, busy};
            default: cur_word = WORD_RESET;
        endcase
    end
    assign merged_word = wr_merge(cur_word, wb_dat_i, wb_sel_i);

    // wishbone answer, one cycle after the request
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= WORD_RESET;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= cur_word;
            end
        end
    end

    // payload registers, frozen while a frame is in flight
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            addr_hi_reg <= WORD_RESET;
            addr_lo_reg <= WORD_RESET;
            net_reg <= HALF_RESET;
            rxopt_reg <= BYTE_RESET;
            ad_ab_reg <= WORD_RESET;
            ad_cd_reg <= WORD_RESET;
            temp_reg <= HALF_RESET;
        end else if (wb_wr && !busy) begin
            case (wb_adr_i)
                OFS_CTRL: ctrl_reg <= merged_word[2:0];
                OFS_ADDR_HI: addr_hi_reg <= merged_word;
                OFS_ADDR_LO: addr_lo_reg <= merged_word;
                OFS_NET: net_reg <= merged_word[15:0];
                OFS_RXOPT: rxopt_reg <= merged_word[7:0];
                OFS_AD_AB: ad_ab_reg <= merged_word;
                OFS_AD_CD: ad_cd_reg <= merged_word;
                OFS_TEMP: temp_reg <= merged_word[15:0];
                default: ;
            endcase
        end
    end

    // lost-sample flag, set wins over clear
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            drop_reg <= 1'b0;
        end else if (drop_set) begin
            drop_reg <= 1'b1;
        end else if (drop_clr) begin
            drop_reg <= 1'b0;
        end
    end

    // water pin synchroniser, change taken when stages two and three agree
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            water_sync_reg <= WATER_SYNC_RESET;
            water_level_reg <= 1'b1;
        end else if (ce_i) begin
            water_sync_reg <= {water_sync_reg[1:0], water_detect_input_i};
            if (water_sync_reg[1] == water_sync_reg[2]) begin
                water_level_reg <= water_sync_reg[2];
            end
        end
    end

    assign addr_word = {addr_hi_reg, addr_lo_reg};
    assign ad_word = ctrl_reg[CTRL_AD_BIT] ? {ad_ab_reg, ad_cd_reg} : {4{NO_READING}};
    assign temp_word = ctrl_reg[CTRL_TEMP_BIT] ? temp_reg : NO_READING;
    assign flags_byte = (ctrl_reg[CTRL_AD_BIT] ? FLAG_AD : BYTE_RESET)
        | (ctrl_reg[CTRL_TEMP_BIT] ? FLAG_TEMP : BYTE_RESET)
        | (water_present ? FLAG_WATER : BYTE_RESET);

    // byte for the current fill position
    always_comb begin
        fill_byte = BYTE_RESET;
        addr_sel = 3'(IDX_ADDR_LAST - fill_idx_reg);
        ad_sel = 3'(IDX_AD_LAST - fill_idx_reg);
        case (fill_idx_reg)
            IDX_START: fill_byte = START_DELIM;
            IDX_LEN_MSB: fill_byte = FRAME_LEN[15:8];
            IDX_LEN_LSB: fill_byte = FRAME_LEN[7:0];
            IDX_TYPE: fill_byte = FRAME_TYPE;
            IDX_NET_MSB: fill_byte = net_reg[15:8];
            IDX_NET_LSB: fill_byte = net_reg[7:0];
            IDX_RXOPT: fill_byte = rxopt_reg & RXOPT_MASK;
            IDX_FLAGS: fill_byte = flags_byte;
            IDX_TEMP_MSB: fill_byte = temp_word[15:8];
            IDX_TEMP_LSB: fill_byte = temp_word[7:0];
            IDX_CSUM: fill_byte = CSUM_BASE - csum_reg;
            default: begin
                if (fill_idx_reg >= IDX_ADDR_FIRST && fill_idx_reg <= IDX_ADDR_LAST) begin
                    fill_byte = addr_word[{addr_sel, 3'b000} +: 8];
                end else if (fill_idx_reg >= IDX_AD_FIRST && fill_idx_reg <= IDX_AD_LAST) begin
                    fill_byte = ad_word[{ad_sel, 3'b000} +: 8];
                end
            end
        endcase
    end

    // running checksum over offsets 3..25
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            csum_reg <= BYTE_RESET;
        end else if (ce_i) begin
            if (frame_go) begin
                csum_reg <= BYTE_RESET;
            end else if (state_reg == ST_FILL && fill_idx_reg >= IDX_TYPE
                         && fill_idx_reg <= IDX_TEMP_LSB) begin
                csum_reg <= csum_reg + fill_byte;
            end
        end
    end

    assign mem_bus.we = (state_reg == ST_FILL);
    assign mem_bus.waddr = fill_idx_reg;
    assign mem_bus.wdata = fill_byte;
    assign mem_bus.raddr = send_idx_reg;

    // frame sequencer: fill store, then read out byte by byte
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            fill_idx_reg <= IDX_START;
            send_idx_reg <= IDX_START;
            count_reg <= BYTE_RESET;
        end else if (ce_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (frame_go) begin
                        state_reg <= ST_FILL;
                        fill_idx_reg <= IDX_START;
                    end
                end
                ST_FILL: begin
                    if (fill_idx_reg == IDX_CSUM) begin
                        state_reg <= ST_RD;
                        send_idx_reg <= IDX_START;
                    end else begin
                        fill_idx_reg <= fill_idx_reg + 5'h01;
                    end
                end
                ST_RD: state_reg <= ST_LD;
                ST_LD: state_reg <= ST_WAIT;
                ST_WAIT: begin
                    if (tx_ready_i) begin
                        if (send_idx_reg == IDX_CSUM) begin
                            state_reg <= ST_IDLE;
                            count_reg <= count_reg + 8'h01;
                        end else begin
                            send_idx_reg <= send_idx_reg + 5'h01;
                            state_reg <= ST_RD;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // byte stream outputs
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid_o <= 1'b0;
            tx_data_o <= BYTE_RESET;
            tx_last_o <= 1'b0;
        end else if (ce_i) begin
            if (state_reg == ST_LD) begin
                tx_valid_o <= 1'b1;
                tx_data_o <= mem_bus.rdata;
                tx_last_o <= (send_idx_reg == IDX_CSUM);
            end else if (tx_fire) begin
                tx_valid_o <= 1'b0;
                tx_last_o <= 1'b0;
            end
        end
    end

    // sum of bytes 3..25 as sent, for checking
    logic [7:0] sent_sum_reg;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sent_sum_reg <= BYTE_RESET;
        end else if (tx_fire) begin
            if (send_idx_reg == IDX_START) begin
                sent_sum_reg <= BYTE_RESET;
            end else if (send_idx_reg >= IDX_TYPE && send_idx_reg <= IDX_TEMP_LSB) begin
                sent_sum_reg <= sent_sum_reg + tx_data_o;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    a_launch_starts: assert property (frame_go |=> state_reg == ST_FILL)
        else $error("accepted sample did not start a frame");
    a_option_blocks: assert property (launch && !busy && merged_word[CTRL_AOO_BIT]
        |=> state_reg == ST_IDLE)
        else $error("frame started with output option set");
    a_start_byte: assert property (tx_valid_o && send_idx_reg == IDX_START
        |-> tx_data_o == START_DELIM)
        else $error("first byte is not the start delimiter");
    a_length_low: assert property (tx_valid_o && send_idx_reg == IDX_LEN_LSB
        |-> tx_data_o == FRAME_LEN[7:0] && (!$rose(tx_valid_o) || $past(tx_valid_o, 3)))
        else $error("length byte wrong");
    a_type_byte: assert property (tx_valid_o && send_idx_reg == IDX_TYPE
        |-> tx_data_o == FRAME_TYPE)
        else $error("frame type byte wrong");
    a_addr_msb_first: assert property (tx_valid_o && send_idx_reg == IDX_ADDR_FIRST
        |-> tx_data_o == addr_hi_reg[31:24])
        else $error("64-bit address not msb first");
    a_addr_lsb_last: assert property (tx_valid_o && send_idx_reg == IDX_ADDR_LAST
        |-> tx_data_o == addr_lo_reg[7:0])
        else $error("64-bit address not lsb last");
    a_net_msb_first: assert property (tx_valid_o && send_idx_reg == IDX_NET_MSB
        |-> tx_data_o == net_reg[15:8])
        else $error("network address not msb first");
    a_rxopt_bits: assert property (tx_valid_o && send_idx_reg == IDX_RXOPT
        |-> tx_data_o == (rxopt_reg & RXOPT_MASK))
        else $error("receive options byte wrong");
    a_sensor_flags: assert property (tx_valid_o && send_idx_reg == IDX_FLAGS
        |-> tx_data_o[1:0] == {ctrl_reg[CTRL_TEMP_BIT], ctrl_reg[CTRL_AD_BIT]})
        else $error("sensor flag bits wrong");
    a_ad_fill: assert property (tx_valid_o && !ctrl_reg[CTRL_AD_BIT]
        && send_idx_reg >= IDX_AD_FIRST && send_idx_reg <= IDX_AD_LAST
        |-> tx_data_o == NO_READING[7:0])
        else $error("absent readings not all ones");
    a_temp_fill: assert property (tx_valid_o && !ctrl_reg[CTRL_TEMP_BIT]
        && send_idx_reg == IDX_TEMP_MSB |-> tx_data_o == NO_READING[15:8])
        else $error("absent thermometer not 0xFFFF");
    a_checksum_value: assert property (tx_valid_o && send_idx_reg == IDX_CSUM
        |-> tx_data_o == 8'(CSUM_BASE - sent_sum_reg) && tx_last_o)
        else $error("checksum byte wrong");
    a_tx_hold: assert property (tx_valid_o && !tx_fire |=> tx_valid_o && $stable(tx_data_o))
        else $error("stream byte dropped before handshake");

    c_frame_done: cover property (tx_fire && tx_last_o);
    c_sample_dropped: cover property (drop_set);
    c_water_flag: cover property (tx_fire && send_idx_reg == IDX_FLAGS && tx_data_o[6:5] == 2'b11);
    c_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_fire);

endmodule

`default_nettype wire

/* File: sensor_read_frame_builder_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module sensor_read_frame_builder_tb
    import sensor_frame_pkg::*;
;
    logic mclk_i = 0, rstn_i = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic water = 1, stall = 0, clear = 0;
    logic [7:0] wb_adr = 8'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_rdat, rd;
    logic wb_ack, tx_valid, tx_last, tx_ready, csum_ok;
    logic [7:0] tx_data;
    logic [7:0] frame [27];
    logic [7:0] exp_b [27];
    logic [5:0] count, last_at;
    logic signed [15:0] temp, te;
    logic [63:0] c_addr;
    logic [15:0] c_net, c_temp;
    logic [7:0] c_rx;
    logic [31:0] c_ab, c_ad2;
    int failures = 0, n_tests = 0;

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    sensor_read_frame_builder i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .water_detect_input_i(water), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .tx_last_o(tx_last));

    frame_host_model i_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .stall_i(stall),
        .clear_i(clear), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
        .tx_ready_o(tx_ready), .frame_o(frame), .count_o(count), .last_at_o(last_at),
        .csum_ok_o(csum_ok), .temp_o(temp));

    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", what, e, g);
            failures++;
        end
    endtask

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge mclk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= s;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 100);
        if (wb_ack !== 1'b1) begin
            $display("ERROR wishbone ack expected 1 seen %b", wb_ack);
            failures++;
            final_report();
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // program payload, launch, collect and compare one frame
    task frame_test(input logic ad, input logic tp, input logic dbl);
        int n;
        logic [7:0] s;
        logic [63:0] adv;
        logic [15:0] tv;
        clear <= 1'b1;
        wb(1'b1, OFS_ADDR_HI, c_addr[63:32], 4'hF);
        clear <= 1'b0;
        wb(1'b1, OFS_ADDR_LO, c_addr[31:0], 4'hF);
        wb(1'b1, OFS_NET, {16'h0, c_net}, 4'hF);
        wb(1'b1, OFS_RXOPT, {24'h0, c_rx}, 4'hF);
        wb(1'b1, OFS_AD_AB, c_ab, 4'hF);
        wb(1'b1, OFS_AD_CD, c_ad2, 4'hF);
        wb(1'b1, OFS_TEMP, {16'h0, c_temp}, 4'hF);
        wb(1'b1, OFS_CTRL, {23'h0, 1'b1, 5'h0, tp, ad, 1'b0}, 4'h3);
        if (dbl) begin
            wb(1'b1, OFS_CTRL, {23'h0, 1'b1, 8'h0}, 4'h3);
            wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
            check("busy during frame", 1, rd[ST_BUSY_BIT]);
            check("dropped launch", 1, rd[ST_DROP_BIT]);
        end
        exp_b[0] = 8'h7E;
        exp_b[1] = 8'h00;
        exp_b[2] = 8'd23;
        exp_b[3] = 8'h94;
        adv = ad ? {c_ab, c_ad2} : 64'hFFFF_FFFF_FFFF_FFFF;
        for (int i = 0; i < 8; i++) begin
            exp_b[4 + i] = c_addr[63 - 8 * i -: 8];
            exp_b[16 + i] = adv[63 - 8 * i -: 8];
        end
        exp_b[12] = c_net[15:8];
        exp_b[13] = c_net[7:0];
        exp_b[14] = c_rx & 8'h23;
        exp_b[15] = {1'b0, ~water, ~water, 3'h0, tp, ad};
        tv = tp ? c_temp : 16'hFFFF;
        exp_b[24] = tv[15:8];
        exp_b[25] = tv[7:0];
        s = 8'h0;
        for (int i = 3; i < 26; i++) begin
            s = s + exp_b[i];
        end
        exp_b[26] = 8'hFF - s;
        n = 0;
        while (count !== 6'd27 && n < 3000) begin
            @(posedge mclk_i);
            n++;
        end
        if (count !== 6'd27) begin
            $display("ERROR frame bytes expected 27 seen %0d", count);
            failures++;
            final_report();
        end
        for (int i = 0; i < 27; i++) begin
            check("frame byte", exp_b[i], frame[i]);
        end
        check("last byte index", 26, last_at);
        check("host checksum", 1, csum_ok);
        te = (c_temp < 16'd2048) ? c_temp : -$signed({5'h0, c_temp[10:0]});
        if (tp) begin
            check("host temperature", te, temp);
        end
        repeat (4) @(posedge mclk_i);
    endtask

    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check("status after reset", 0, rd);
        wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
        check("control after reset", 0, rd);
        wb(1'b1, 8'h40, 32'hA5A5_A5A5, 4'hF);
        wb(1'b0, 8'h40, 32'h0, 4'hF);
        check("unmapped read", 0, rd);
        $display("test reset and map done");

        c_addr = 64'h0013_A200_4052_2BAA;
        c_net = 16'hDD6C;
        c_rx = 8'hFF;
        c_ab = 32'h0002_00CE;
        c_ad2 = 32'h00EA_0052;
        c_temp = 16'h816A;
        water <= 1'b0;
        stall <= 1'b1;
        repeat (8) @(posedge mclk_i);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check("water present", 1, rd[ST_WATER_BIT]);
        frame_test(1'b1, 1'b1, 1'b0);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check("frame count", 1, rd[15:8]);
        $display("test full frame done");

        c_rx = 8'h21;
        c_temp = 16'h016A;
        water <= 1'b1;
        stall <= 1'b0;
        repeat (8) @(posedge mclk_i);
        frame_test(1'b0, 1'b0, 1'b1);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check("status after drop", 32'h0000_0204, rd);
        wb(1'b1, OFS_STATUS, 32'h0000_0004, 4'hF);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check("status after clear", 32'h0000_0200, rd);
        $display("test empty frame and drop done");

        clear <= 1'b1;
        wb(1'b1, OFS_CTRL, {23'h0, 1'b1, 8'h01}, 4'h3);
        clear <= 1'b0;
        repeat (80) @(posedge mclk_i);
        check("bytes with option set", 0, count);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check("status with option set", 32'h0000_0200, rd);
        $display("test output option done");
        final_report();
    end
endmodule

`default_nettype wire
